// *** common/fsl_pkg.sv ***
// Package of constants and types for the slave status indicator driver
package fsl_pkg;

    // Clock rate and pattern timing
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned MS_PER_S      = 1000;
    localparam int unsigned TICK_CYCLES   = CLK_HZ / MS_PER_S; // Per ms
    localparam int unsigned SHORT_MS      = 200;   // Lit / short dark phase
    localparam int unsigned LONG_MS       = 1000;  // Long dark phase
    localparam int unsigned ACT_MS        = 50;    // Activity flash phase
    localparam int unsigned MS_W          = 11;    // Phase counter width

    // Register map (byte addresses)
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_STATE     = 8'h04;
    localparam logic [7:0] ADDR_FAULT     = 8'h08;
    localparam logic [7:0] ADDR_LINK      = 8'h0c;
    localparam logic [7:0] ADDR_LAMPS     = 8'h10;

    // Control field positions
    localparam int unsigned CTRL_CFG_BIT  = 0;
    localparam int unsigned CTRL_APPWD_BIT = 1;
    localparam int unsigned CTRL_HSWD_BIT = 2;
    localparam int unsigned CTRL_LINK0    = 3;
    localparam int unsigned CTRL_LINK1    = 4;
    localparam int unsigned CTRL_ACT0     = 5;
    localparam int unsigned CTRL_ACT1     = 6;
    localparam int unsigned CHG_LSB       = 8;
    localparam logic [7:0]  CHG_UNSOL     = 8'h01;

    // AXI responses
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

    // Slave state machine state
    typedef enum logic [1:0] {
        ST_POWERUP = 2'b00,
        ST_PREP    = 2'b01,
        ST_INPUTS  = 2'b10,
        ST_FULL    = 2'b11
    } fsl_state_type;

    // Indicator pattern selection
    typedef enum logic [2:0] {
        PAT_OFF    = 3'b000,
        PAT_ON     = 3'b001,
        PAT_BLINK  = 3'b010,
        PAT_SINGLE = 3'b011,
        PAT_DOUBLE = 3'b100
    } fsl_pat_type;

    // Lamp outputs travelling together
    typedef struct packed {
        logic       state_green;
        logic       fault_red;
        logic [1:0] link_green;
        logic [1:0] unused_yellow;
    } fsl_lamps_type;

endpackage : fsl_pkg

// *** hw/fsl_pattern_gen.sv ***
// Shared pattern timer producing blink, single and double flash levels
`timescale 1ns/1ps
module fsl_pattern_gen (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    input  wire logic ms_tick,
    output logic      blink,
    output logic      single,
    output logic      dbl,
    output logic      act
);
    import fsl_pkg::*;

    localparam logic [MS_W-1:0] SHORT_L = MS_W'(SHORT_MS);
    localparam logic [MS_W-1:0] LONG_L  = MS_W'(LONG_MS);
    localparam logic [MS_W-1:0] ACT_L   = MS_W'(ACT_MS);
    localparam logic [MS_W-1:0] ONE_L   = MS_W'(1);

    logic [MS_W-1:0] bl_cnt_r;   // Blink phase ms count
    logic [MS_W-1:0] sf_cnt_r;   // Single flash phase count
    logic [MS_W-1:0] df_cnt_r;   // Double flash phase count
    logic [MS_W-1:0] ac_cnt_r;   // Activity phase count
    logic [1:0]      df_ph_r;    // Double flash phase index
    logic            sf_ph_r;    // Single flash phase, 0 = lit

    // Phase end test used by every pattern
    function automatic logic phase_end(input logic [MS_W-1:0] c,
                                       input logic [MS_W-1:0] len);
        phase_end = (c == len - ONE_L);
    endfunction : phase_end

    // Blink: 200 ms lit then 200 ms dark; starts lit after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bl_cnt_r <= '0;
            blink    <= 1'b1;
        end else if (ce && ms_tick) begin
            if (phase_end(bl_cnt_r, SHORT_L)) begin
                bl_cnt_r <= '0;
                blink    <= ~blink;
            end else begin
                bl_cnt_r <= bl_cnt_r + ONE_L;
            end
        end
    end

    // Single flash: 200 ms lit, 1000 ms dark
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sf_cnt_r <= '0;
            sf_ph_r  <= 1'b0;
            single   <= 1'b1;
        end else if (ce && ms_tick) begin
            if (phase_end(sf_cnt_r, sf_ph_r ? LONG_L : SHORT_L)) begin
                sf_cnt_r <= '0;
                sf_ph_r  <= ~sf_ph_r;
                single   <= sf_ph_r;
            end else begin
                sf_cnt_r <= sf_cnt_r + ONE_L;
            end
        end
    end

    // Double flash: lit, dark, lit at 200 ms each, then 1000 ms dark
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            df_cnt_r <= '0;
            df_ph_r  <= 2'b00;
            dbl      <= 1'b1;
        end else if (ce && ms_tick) begin
            if (phase_end(df_cnt_r, (df_ph_r == 2'b11) ? LONG_L : SHORT_L))
            begin
                df_cnt_r <= '0;
                df_ph_r  <= df_ph_r + 2'b01;
                // Next phase lit only for index 0 and 2
                dbl      <= (df_ph_r == 2'b01) || (df_ph_r == 2'b11);
            end else begin
                df_cnt_r <= df_cnt_r + ONE_L;
            end
        end
    end

    // Fast activity flicker, 50 ms per phase
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ac_cnt_r <= '0;
            act      <= 1'b1;
        end else if (ce && ms_tick) begin
            if (phase_end(ac_cnt_r, ACT_L)) begin
                ac_cnt_r <= '0;
                act      <= ~act;
            end else begin
                ac_cnt_r <= ac_cnt_r + ONE_L;
            end
        end
    end

    // Blink never toggles before a half period of 200 ms of ticks has run
    blink_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !(ce && ms_tick && bl_cnt_r == SHORT_L - ONE_L) |=> $stable(blink))
        else $error("blink toggled early");
    single_lit_a: assert property (@(posedge aclk) disable iff (!aresetn)
        single |-> !sf_ph_r)
        else $error("single flash lit in dark phase");
    double_dark_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (df_ph_r[0] || $past(df_ph_r) == 2'b11 && df_ph_r == 2'b11)
        |-> !dbl || df_ph_r == 2'b00)
        else $error("double flash lit in dark phase");

endmodule : fsl_pattern_gen

// *** hw/fsl_status_leds.sv ***
// Top of the slave status indicator driver with AXI4-Lite registers
`timescale 1ns/1ps
module fsl_status_leds #(
    parameter int unsigned TICK_DIV = fsl_pkg::TICK_CYCLES // Cycles per ms
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 ce,
    // AXI4-Lite write address
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Indicator lamps
    output fsl_pkg::fsl_lamps_type    lamps
);
    import fsl_pkg::*;

    localparam logic [31:0] DIV_LAST = 32'(TICK_DIV - 1);

    logic [31:0]   div_r;        // Millisecond divider
    logic          tick_r;       // One-cycle ms tick
    logic          blink;        // Shared blink level
    logic          single;       // Shared single flash level
    logic          dbl;          // Shared double flash level
    logic          act;          // Activity flicker level
    fsl_state_type state_r;      // Slave state written by firmware
    logic [31:0]   ctrl_r;       // Fault, link and change fields
    fsl_pat_type   run_pat;      // Pattern for state lamp
    fsl_pat_type   err_pat;      // Pattern for fault lamp
    fsl_pat_type   err_pat_r;    // Registered fault pattern for readback
    logic          aw_hold_r;    // Write address captured
    logic          w_hold_r;     // Write data captured
    logic [7:0]    aw_addr_r;    // Captured write address
    logic [31:0]   w_data_r;     // Captured write data
    logic [3:0]    w_strb_r;     // Captured strobes

    // Map a pattern to a lamp level; steady ones are plain constants
    function automatic logic pat_level(input fsl_pat_type p,
                                       input logic b, input logic s,
                                       input logic d);
        case (p)
            PAT_ON:     pat_level = 1'b1;
            PAT_BLINK:  pat_level = b;
            PAT_SINGLE: pat_level = s;
            PAT_DOUBLE: pat_level = d;
            default:    pat_level = 1'b0;
        endcase
    endfunction : pat_level

    // Byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] st);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : merge

    // Millisecond tick from the system clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_r  <= '0;
            tick_r <= 1'b0;
        end else if (ce) begin
            tick_r <= (div_r == DIV_LAST);
            div_r  <= (div_r == DIV_LAST) ? '0 : div_r + 32'd1;
        end
    end

    // Pattern timers shared by the state, fault and link lamps
    fsl_pattern_gen u_pat (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .ms_tick (tick_r),
        .blink   (blink),
        .single  (single),
        .dbl     (dbl),
        .act     (act)
    );

    // State lamp pattern from slave state
    always_comb begin
        case (state_r)
            ST_PREP:   run_pat = PAT_BLINK;
            ST_INPUTS: run_pat = PAT_SINGLE;
            ST_FULL:   run_pat = PAT_ON;
            default:   run_pat = PAT_OFF;
        endcase
    end

    // Fault lamp pattern, most severe fault first
    always_comb begin
        if (ctrl_r[CTRL_HSWD_BIT]) begin
            err_pat = PAT_ON;
        end else if (ctrl_r[CTRL_APPWD_BIT]) begin
            err_pat = PAT_DOUBLE;
        end else if (ctrl_r[CHG_LSB +: 8] == CHG_UNSOL) begin
            err_pat = PAT_SINGLE;
        end else if (ctrl_r[CTRL_CFG_BIT]) begin
            err_pat = PAT_BLINK;
        end else begin
            err_pat = PAT_OFF;
        end
    end

    // Lamp registers; all outputs come from flip-flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lamps     <= '0;
            err_pat_r <= PAT_OFF;
        end else if (ce) begin
            err_pat_r           <= err_pat;
            lamps.state_green   <= pat_level(run_pat, blink, single, dbl);
            lamps.fault_red     <= pat_level(err_pat, blink, single, dbl);
            // Link on steady, flicker while traffic runs
            lamps.link_green[0] <= ctrl_r[CTRL_LINK0] &&
                (!ctrl_r[CTRL_ACT0] || act);
            lamps.link_green[1] <= ctrl_r[CTRL_LINK1] &&
                (!ctrl_r[CTRL_ACT1] || act);
            lamps.unused_yellow <= '0;
        end
    end

    // Write channel: take address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r     <= 1'b0;
            w_hold_r      <= 1'b0;
            aw_addr_r     <= '0;
            w_data_r      <= '0;
            w_strb_r      <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            state_r       <= ST_POWERUP;
            ctrl_r        <= '0;
        end else if (ce) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && !aw_hold_r && !s_axi_awready &&
                !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
                aw_hold_r     <= 1'b1;
                aw_addr_r     <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_hold_r && !s_axi_wready &&
                !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
                w_hold_r     <= 1'b1;
                w_data_r     <= s_axi_wdata;
                w_strb_r     <= s_axi_wstrb;
            end
            // Both halves present: commit and answer
            if (aw_hold_r && w_hold_r && !s_axi_bvalid) begin
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= RESP_OKAY;
                case (aw_addr_r)
                    ADDR_CTRL:  ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r);
                    ADDR_STATE: begin
                        if (w_strb_r[0]) begin
                            state_r <= fsl_state_type'(w_data_r[1:0]);
                        end
                    end
                    default:    s_axi_bresp <= RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel: one cycle to answer, held until rready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (ce) begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
            end else if (s_axi_arvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= RESP_OKAY;
                case (s_axi_araddr)
                    ADDR_CTRL:  s_axi_rdata <= ctrl_r;
                    ADDR_STATE: s_axi_rdata <= {30'h0, state_r};
                    ADDR_FAULT: s_axi_rdata <= {29'h0, err_pat_r};
                    ADDR_LINK:  s_axi_rdata <= {28'h0, lamps.link_green,
                                                ctrl_r[CTRL_LINK1],
                                                ctrl_r[CTRL_LINK0]};
                    ADDR_LAMPS: s_axi_rdata <= {26'h0, lamps};
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // Checks on the lamp logic and the bus answers; a lamp lags its cause by one edge

    // Settled power-up, dark lamp
    powerup_off_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ce && $past(ce) && state_r == ST_POWERUP &&
        $past(state_r) == ST_POWERUP |-> !lamps.state_green)
        else $error("state lamp lit in power-up");

    // Full exchange, steady lamp
    full_on_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (ce && state_r == ST_FULL) ##1 ce |-> lamps.state_green)
        else $error("state lamp dark in full exchange");

    // Preparatory state blinks
    prep_blink_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (ce && state_r == ST_PREP) |=> lamps.state_green == $past(blink))
        else $error("state lamp not blinking");

    // Inputs-only state single-flashes
    inputs_flash_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (ce && state_r == ST_INPUTS) |=> lamps.state_green == $past(single))
        else $error("state lamp not single flashing");

    // Host watchdog outranks all
    hswd_on_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (ce && ctrl_r[CTRL_HSWD_BIT]) |=> lamps.fault_red)
        else $error("fault lamp dark on host watchdog");

    // Application watchdog double-flashes
    appwd_dbl_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (ce && ctrl_r[CTRL_APPWD_BIT] && !ctrl_r[CTRL_HSWD_BIT])
        |=> lamps.fault_red == $past(dbl))
        else $error("fault lamp not double flashing");

    // Unsolicited change, no watchdog
    unsol_flash_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (ce && ctrl_r[CHG_LSB +: 8] == CHG_UNSOL &&
         ctrl_r[CTRL_HSWD_BIT:CTRL_APPWD_BIT] == 2'b00)
        |=> lamps.fault_red == $past(single))
        else $error("fault lamp not single flashing");

    // Configuration error alone blinks
    cfg_blink_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (ce && ctrl_r[CTRL_HSWD_BIT:CTRL_CFG_BIT] == 3'b001 &&
         ctrl_r[CHG_LSB +: 8] != CHG_UNSOL)
        |=> lamps.fault_red == $past(blink))
        else $error("fault lamp not blinking");

    // No fault, dark lamp
    no_fault_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (ce && ctrl_r[CTRL_HSWD_BIT:CTRL_CFG_BIT] == 3'b000 &&
         ctrl_r[CHG_LSB +: 8] != CHG_UNSOL) |=> !lamps.fault_red)
        else $error("fault lamp lit without fault");

    // No link, dark lamp even with traffic
    no_link_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (ce && !ctrl_r[CTRL_LINK0]) |=> !lamps.link_green[0])
        else $error("link lamp lit without link");

    no_link1_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (ce && !ctrl_r[CTRL_LINK1]) |=> !lamps.link_green[1])
        else $error("port 1 link lamp lit without link");

    // Quiet link, steady lamp
    link_on_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (ce && ctrl_r[CTRL_LINK0] && !ctrl_r[CTRL_ACT0])
        |=> lamps.link_green[0])
        else $error("link lamp dark with quiet link");

    // Yellow lamps unused
    yellow_off_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        lamps.unused_yellow == 2'b00)
        else $error("yellow lamp driven");

    // Write answer stands until taken
    bresp_hold_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready)
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");

    // Read answer stands until taken
    rdata_hold_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (s_axi_rvalid && !s_axi_rready)
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");

endmodule : fsl_status_leds

// *** verification/fsl_lamp_model.sv ***
// Operator-eye model that times the lit and dark runs of one lamp
`timescale 1ns/1ps
module fsl_lamp_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clr,
    input  wire logic        lamp,
    output logic [15:0]      lit_min,
    output logic [15:0]      lit_max,
    output logic [15:0]      dark_min,
    output logic [15:0]      dark_max,
    output logic [15:0]      edges
);
    logic        prev_r; // Level seen on the last edge
    logic        seen_r; // A change was seen since clear
    logic [15:0] run_r;  // Cycles spent at the current level

    // Only runs bounded by two changes count, so a window that opens
    // mid-phase never reports a truncated phase
    always_ff @(posedge aclk) begin
        if (!aresetn || clr) begin
            prev_r   <= lamp;
            seen_r   <= 1'b0;
            run_r    <= 16'h0001;
            edges    <= 16'h0000;
            lit_min  <= 16'hffff;
            lit_max  <= 16'h0000;
            dark_min <= 16'hffff;
            dark_max <= 16'h0000;
        end else if (lamp != prev_r) begin
            prev_r <= lamp;
            seen_r <= 1'b1;
            run_r  <= 16'h0001;
            edges  <= edges + 16'h0001;
            // Record the run that just ended
            if (seen_r && prev_r) begin
                if (run_r < lit_min) lit_min <= run_r;
                if (run_r > lit_max) lit_max <= run_r;
            end else if (seen_r) begin
                if (run_r < dark_min) dark_min <= run_r;
                if (run_r > dark_max) dark_max <= run_r;
            end
        end else begin
            run_r <= run_r + 16'h0001;
        end
    end
endmodule : fsl_lamp_model

// *** verification/tb_top.sv ***
// Self-checking bench for the status indicator driver
`timescale 1ns/1ps
module tb_top;
    import fsl_pkg::*;
    localparam int TD = 10;               // Short ms tick for sim
    localparam int SH = SHORT_MS * TD;    // Short phase in cycles
    localparam int LG = LONG_MS * TD;     // Long dark phase in cycles
    logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid;
    logic bready, arvalid, arready, rvalid, rready, clr;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    fsl_lamps_type lamps;
    logic [15:0] s_lmin, s_lmax, s_dmin, s_dmax, s_ed;
    logic [15:0] f_lmin, f_lmax, f_dmin, f_dmax, f_ed;
    logic [15:0] k_lmin, k_lmax, k_dmin, k_dmax, k_ed;
    int err_count, n_tests;
    logic [31:0] ctl_t [5] = '{32'h103, 32'h101, 32'h201, 32'h100, 32'h0};
    logic [31:0] flt_t [5] = '{32'h4, 32'h3, 32'h2, 32'h3, 32'h0};

    fsl_status_leds #(.TICK_DIV(TD)) u_fsl_status_leds (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .lamps(lamps));
    // One eye on the state, fault and port 0 link lamps
    fsl_lamp_model u_fsl_lamp_model_st (.aclk(aclk), .aresetn(aresetn),
        .clr(clr), .lamp(lamps.state_green), .lit_min(s_lmin),
        .lit_max(s_lmax), .dark_min(s_dmin), .dark_max(s_dmax),
        .edges(s_ed));
    fsl_lamp_model u_fsl_lamp_model_fl (.aclk(aclk), .aresetn(aresetn),
        .clr(clr), .lamp(lamps.fault_red), .lit_min(f_lmin),
        .lit_max(f_lmax), .dark_min(f_dmin), .dark_max(f_dmax),
        .edges(f_ed));
    fsl_lamp_model u_fsl_lamp_model_lk (.aclk(aclk), .aresetn(aresetn),
        .clr(clr), .lamp(lamps.link_green[0]), .lit_min(k_lmin),
        .lit_max(k_lmax), .dark_min(k_dmin), .dark_max(k_dmax),
        .edges(k_ed));

    // Clock generator, 100 MHz
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : chk

    task automatic end_sim;
        $display("Checks %0d, errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim

    // Write one word; address and data are released as each is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
        @(posedge aclk);
    endtask : wr

    // Read one word and hold rready until the data arrive
    task automatic rdw(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata; r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rdw

    // Restart all lamp eyes, then watch for n cycles
    task automatic watch(input int n);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        repeat (n) @(posedge aclk);
    endtask : watch

    task automatic t_reset;
        for (int i = 0; i < 5; i++) begin
            rdw(8'(4 * i), rd, rs);
            chk(rd, 32'h0);
        end
        rdw(8'h20, rd, rs);
        chk({rd[29:0], rs}, 32'h2);
        wr(8'h20, 32'h1, RESP_SLVERR);
        watch(300);
        chk({s_ed, f_ed}, 32'h0);
        chk({lamps.state_green, lamps.fault_red}, 32'h0);
    endtask : t_reset

    task automatic t_blink;
        wr(ADDR_STATE, 32'h1, RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk(lamps.state_green, 32'h1);
        wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        watch(3 * SH);
        chk({s_lmin, s_lmax}, {SH[15:0], SH[15:0]});
        chk({s_dmin, s_dmax}, {SH[15:0], SH[15:0]});
        chk({f_lmin, f_dmax}, {SH[15:0], SH[15:0]});
        rdw(ADDR_FAULT, rd, rs);
        chk(rd, 32'h2);
    endtask : t_blink

    task automatic t_steady;
        wr(ADDR_STATE, 32'h3, RESP_OKAY);
        wr(ADDR_CTRL, 32'h7, RESP_OKAY);
        watch(3000);
        chk({s_ed, f_ed}, 32'h0);
        chk({lamps.state_green, lamps.fault_red}, 32'h3);
        rdw(ADDR_FAULT, rd, rs);
        chk(rd, 32'h1);
    endtask : t_steady

    task automatic t_flash;
        wr(ADDR_STATE, 32'h2, RESP_OKAY);
        wr(ADDR_CTRL, 32'h2, RESP_OKAY);
        watch(2 * LG + 5 * SH);
        chk({s_lmin, s_lmax}, {SH[15:0], SH[15:0]});
        chk({s_dmin, s_dmax}, {LG[15:0], LG[15:0]});
        chk({f_lmin, f_lmax}, {SH[15:0], SH[15:0]});
        chk({f_dmin, f_dmax}, {SH[15:0], LG[15:0]});
    endtask : t_flash

    task automatic t_rank;
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_CTRL, ctl_t[i], RESP_OKAY);
            rdw(ADDR_FAULT, rd, rs);
            chk(rd, flt_t[i]);
        end
    endtask : t_rank

    task automatic t_link;
        wr(ADDR_CTRL, 32'h48, RESP_OKAY);
        watch(2000);
        chk({k_ed, 15'h0, lamps.link_green[0]}, 32'h1);
        chk(lamps.link_green[1], 32'h0);
        rdw(ADDR_LINK, rd, rs);
        chk(rd, 32'h5);
        wr(ADDR_CTRL, 32'h18, RESP_OKAY);
        rdw(ADDR_LINK, rd, rs);
        chk(rd, 32'hf);
        wr(ADDR_CTRL, 32'h68, RESP_OKAY);
        watch(3000);
        chk({k_lmin, k_lmax}, {16'(ACT_MS * TD), 16'(ACT_MS * TD)});
        // Clock enable low must freeze the flicker too
        ce <= 1'b0;
        watch(1200);
        chk(k_ed, 32'h0);
        ce <= 1'b1;
    endtask : t_link

    // Yellow lamps must stay dark at every edge
    always @(posedge aclk) begin
        if (aresetn && lamps.unused_yellow !== 2'h0) begin
            $display("ERROR t=%0t got=%h exp=%h", $time,
                     lamps.unused_yellow, 2'h0);
            err_count++;
        end
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (90000) @(posedge aclk);
        err_count++;
        end_sim();
    end

    // Main sequence
    initial begin
        err_count = 0; n_tests = 0; aresetn = 1'b0; ce = 1'b1; clr = 1'b0;
        awaddr = 8'h0; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'hf;
        wvalid = 1'b0; bready = 1'b0; araddr = 8'h0; arvalid = 1'b0;
        rready = 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_blink();
        t_steady();
        t_flash();
        t_rank();
        t_link();
        end_sim();
    end
endmodule : tb_top
